/* lrc_pkg.sv */
/*
 * lrc_pkg: constants and types for the linear regulator control block.
 * assumes: a single 100 MHz clock domain; no register bus.
 */
`default_nettype none

package lrc_pkg;

    // ---------------------------------------------------------------
    // system power states as seen by the regulator
    // ---------------------------------------------------------------
    typedef enum logic [1:0]
    {
        LRC_PWR_OFF,
        LRC_PWR_RUN,
        LRC_PWR_STANDBY,
        LRC_PWR_QOFF
    } lrc_pwr_state_t;

    // ---------------------------------------------------------------
    // regulator operating modes
    // ---------------------------------------------------------------
    typedef enum logic [1:0]
    {
        LRC_MODE_DISABLED,
        LRC_MODE_REGULATE,
        LRC_MODE_SWITCH
    } lrc_mode_t;

    // ---------------------------------------------------------------
    // widths and reset values
    // ---------------------------------------------------------------
    localparam int LRC_SP_W = 4;
    localparam int LRC_MV_W = 13;
    localparam logic [LRC_SP_W-1:0] LRC_SP_RESET = 4'h0;
    localparam logic LRC_EN_RESET = 1'b0;

    // ---------------------------------------------------------------
    // set-point decode, output in millivolts
    // ---------------------------------------------------------------
    function automatic logic [LRC_MV_W-1:0] lrc_sp_to_mv(
        input logic [LRC_SP_W-1:0] code
    );
        logic [LRC_MV_W-1:0] mv;
        mv = 13'h05DC;
        unique case (code)
            4'h0: mv = 13'h05DC; // 1500
            4'h1: mv = 13'h0640; // 1600
            4'h2: mv = 13'h0708; // 1800
            4'h3: mv = 13'h073A; // 1850
            4'h4: mv = 13'h0866; // 2150
            4'h5: mv = 13'h09C4; // 2500
            4'h6: mv = 13'h0AF0; // 2800
            4'h7: mv = 13'h0BB8; // 3000
            4'h8: mv = 13'h0C1C; // 3100
            4'h9: mv = 13'h0C4E; // 3150
            4'hA: mv = 13'h0C80; // 3200
            4'hB: mv = 13'h0CE4; // 3300
            4'hC: mv = 13'h0D16; // 3350
            4'hD: mv = 13'h0FA0; // 4000
            4'hE: mv = 13'h1324; // 4900
            4'hF: mv = 13'h1388; // 5000
        endcase
        return mv;
    endfunction

endpackage

`default_nettype wire

/* lrc_linreg_ctrl.sv */
/*
 * lrc_linreg_ctrl: control logic for linear regulator one.
 * Holds the run/standby enables and set-points, and derives the analog
 * controls (enable, mode, pass-through, discharge, current limit).
 * assumes: all inputs come from logic on clk_i; software writes arrive
 * as one-cycle write strobes with data; the power sequencer drives the
 * power state and the power-up load and sequence strobes.
 * Every control output is registered: it follows a setting write two
 * edges later and a power state change one edge later.
 * limitation: the switch select is only taken at the power-up load,
 * software has no way to change it afterwards.
 */
`timescale 1ns/10ps
`default_nettype none

// Operation
// - run enable low turns regulator off
// - standby enable low turns regulator off
// - power-up load clears both enables, else sequence sets both, else writes or hold
// - disabled means output pull-down active
// - enabled: nvm bit picks regulate or switch
// - run and standby use separate set-points
// - power-up loads both set-points from nvm
// - decode code to sixteen rising levels
// - switch select passes input to output
// - enable bit opens or closes switch
// - current limit only when limit bit set
// - test mode in quiescent off: weak pull-down
module lrc_linreg_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire lrc_pkg::lrc_pwr_state_t pwr_state_i,
    input wire logic powerup_load_i,
    input wire logic in_sequence_i,
    input wire logic seq_enable_i,
    input wire logic nvm_linreg_switch_select_i,
    input wire logic [lrc_pkg::LRC_SP_W-1:0] nvm_linreg_setpoint_i,
    input wire logic run_enable_we_i,
    input wire logic run_enable_wdata_i,
    input wire logic standby_enable_we_i,
    input wire logic standby_enable_wdata_i,
    input wire logic run_setpoint_we_i,
    input wire logic [lrc_pkg::LRC_SP_W-1:0] run_setpoint_wdata_i,
    input wire logic standby_setpoint_we_i,
    input wire logic [lrc_pkg::LRC_SP_W-1:0] standby_setpoint_wdata_i,
    input wire logic switch_current_limit_enable_i,
    input wire logic test_board_mode_enable_i,
    output logic linreg_run_enable_o,
    output logic linreg_standby_enable_o,
    output logic [lrc_pkg::LRC_SP_W-1:0] linreg_run_setpoint_o,
    output logic [lrc_pkg::LRC_SP_W-1:0] linreg_standby_setpoint_o,
    output logic linreg_switch_select_o,
    output lrc_pkg::lrc_mode_t mode_o,
    output logic reg_on_o,
    output logic pass_through_o,
    output logic [lrc_pkg::LRC_SP_W-1:0] active_setpoint_o,
    output logic [lrc_pkg::LRC_MV_W-1:0] target_mv_o,
    output logic discharge_o,
    output logic weak_pulldown_o,
    output logic current_limit_o
);

    // ---------------------------------------------------------------
    // state enables
    // ---------------------------------------------------------------
    logic run_en_reg;
    logic run_en_next;
    logic stby_en_reg;
    logic stby_en_next;

    // priority, lowest first: software write, sequencer set, power-up
    // clear; the load must always leave both enables cleared
    always_comb
    begin
        run_en_next = run_en_reg;
        stby_en_next = stby_en_reg;
        if (run_enable_we_i)
        begin
            run_en_next = run_enable_wdata_i;
        end
        if (standby_enable_we_i)
        begin
            stby_en_next = standby_enable_wdata_i;
        end
        if (seq_enable_i && in_sequence_i)
        begin
            run_en_next = 1'b1;
            stby_en_next = 1'b1;
        end
        if (powerup_load_i)
        begin
            run_en_next = lrc_pkg::LRC_EN_RESET;
            stby_en_next = lrc_pkg::LRC_EN_RESET;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            run_en_reg <= lrc_pkg::LRC_EN_RESET;
            stby_en_reg <= lrc_pkg::LRC_EN_RESET;
        end
        else
        begin
            run_en_reg <= run_en_next;
            stby_en_reg <= stby_en_next;
        end
    end

    // ---------------------------------------------------------------
    // set-points and switch select
    // ---------------------------------------------------------------
    logic [lrc_pkg::LRC_SP_W-1:0] run_sp_reg;
    logic [lrc_pkg::LRC_SP_W-1:0] run_sp_next;
    logic [lrc_pkg::LRC_SP_W-1:0] stby_sp_reg;
    logic [lrc_pkg::LRC_SP_W-1:0] stby_sp_next;
    logic ls_sel_reg;
    logic ls_sel_next;

    // the nvm load beats a same-cycle write, since the defaults must land
    always_comb
    begin
        run_sp_next = run_sp_reg;
        stby_sp_next = stby_sp_reg;
        ls_sel_next = ls_sel_reg;
        if (run_setpoint_we_i)
        begin
            run_sp_next = run_setpoint_wdata_i;
        end
        if (standby_setpoint_we_i)
        begin
            stby_sp_next = standby_setpoint_wdata_i;
        end
        if (powerup_load_i)
        begin
            run_sp_next = nvm_linreg_setpoint_i;
            stby_sp_next = nvm_linreg_setpoint_i;
            ls_sel_next = nvm_linreg_switch_select_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            run_sp_reg <= lrc_pkg::LRC_SP_RESET;
            stby_sp_reg <= lrc_pkg::LRC_SP_RESET;
            ls_sel_reg <= 1'b0;
        end
        else
        begin
            run_sp_reg <= run_sp_next;
            stby_sp_reg <= stby_sp_next;
            ls_sel_reg <= ls_sel_next;
        end
    end

    // ---------------------------------------------------------------
    // power state selection
    // ---------------------------------------------------------------
    logic act_en;
    logic [lrc_pkg::LRC_SP_W-1:0] act_sp;
    logic in_qoff;

    // selection follows the live state, so a run/standby move takes
    // effect on the very next edge
    always_comb
    begin
        act_en = 1'b0;
        act_sp = run_sp_reg;
        in_qoff = 1'b0;
        unique case (pwr_state_i)
            lrc_pkg::LRC_PWR_RUN:
            begin
                act_en = run_en_reg;
                act_sp = run_sp_reg;
            end
            lrc_pkg::LRC_PWR_STANDBY:
            begin
                act_en = stby_en_reg;
                act_sp = stby_sp_reg;
            end
            lrc_pkg::LRC_PWR_OFF:
            begin
                act_en = 1'b0;
                act_sp = run_sp_reg;
            end
            // quiescent off also arms the test-mode pull-down
            lrc_pkg::LRC_PWR_QOFF:
            begin
                act_en = 1'b0;
                act_sp = run_sp_reg;
                in_qoff = 1'b1;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // analog control derivation
    // ---------------------------------------------------------------
    logic on_reg;
    logic on_next;
    lrc_pkg::lrc_mode_t mode_reg;
    lrc_pkg::lrc_mode_t mode_next;
    logic pass_reg;
    logic pass_next;
    logic dis_reg;
    logic dis_next;
    logic weak_reg;
    logic weak_next;
    logic ilim_reg;
    logic ilim_next;
    logic [lrc_pkg::LRC_SP_W-1:0] asp_reg;
    logic [lrc_pkg::LRC_SP_W-1:0] asp_next;
    logic [lrc_pkg::LRC_MV_W-1:0] mv_reg;
    logic [lrc_pkg::LRC_MV_W-1:0] mv_next;

    // exactly one of discharge and weak pull-down is on while off, and
    // neither while on, so the two paths never fight the output
    always_comb
    begin
        on_next = act_en;
        pass_next = 1'b0;
        mode_next = lrc_pkg::LRC_MODE_DISABLED;
        dis_next = 1'b0;
        weak_next = 1'b0;
        ilim_next = 1'b0;
        asp_next = act_sp;
        mv_next = lrc_pkg::lrc_sp_to_mv(act_sp);
        if (!act_en)
        begin
            mode_next = lrc_pkg::LRC_MODE_DISABLED;
            if (test_board_mode_enable_i && in_qoff)
            begin
                weak_next = 1'b1;
            end
            else
            begin
                dis_next = 1'b1;
            end
        end
        else if (ls_sel_reg)
        begin
            mode_next = lrc_pkg::LRC_MODE_SWITCH;
            pass_next = 1'b1;
            ilim_next = switch_current_limit_enable_i;
        end
        else
        begin
            mode_next = lrc_pkg::LRC_MODE_REGULATE;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            on_reg <= 1'b0;
            mode_reg <= lrc_pkg::LRC_MODE_DISABLED;
            pass_reg <= 1'b0;
            dis_reg <= 1'b1;
            weak_reg <= 1'b0;
            ilim_reg <= 1'b0;
            asp_reg <= lrc_pkg::LRC_SP_RESET;
            mv_reg <= lrc_pkg::lrc_sp_to_mv(lrc_pkg::LRC_SP_RESET);
        end
        else
        begin
            on_reg <= on_next;
            mode_reg <= mode_next;
            pass_reg <= pass_next;
            dis_reg <= dis_next;
            weak_reg <= weak_next;
            ilim_reg <= ilim_next;
            asp_reg <= asp_next;
            mv_reg <= mv_next;
        end
    end

    // every output is a plain copy of a flop, with no logic after it
    always_comb
    begin
        linreg_run_enable_o = run_en_reg;
        linreg_standby_enable_o = stby_en_reg;
        linreg_run_setpoint_o = run_sp_reg;
        linreg_standby_setpoint_o = stby_sp_reg;
        linreg_switch_select_o = ls_sel_reg;
        mode_o = mode_reg;
        reg_on_o = on_reg;
        pass_through_o = pass_reg;
        active_setpoint_o = asp_reg;
        target_mv_o = mv_reg;
        discharge_o = dis_reg;
        weak_pulldown_o = weak_reg;
        current_limit_o = ilim_reg;
    end

endmodule

`default_nettype wire

/* lrc_linreg_ctrl_monitor.sv */
/* checker for lrc_linreg_ctrl ports.
 * assumes: bound to the design, one clock, rst_i sync. */
`timescale 1ns/10ps
`default_nettype none
module lrc_linreg_ctrl_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire lrc_pkg::lrc_pwr_state_t pwr_state_i,
    input wire logic powerup_load_i,
    input wire logic in_sequence_i,
    input wire logic seq_enable_i,
    input wire logic nvm_linreg_switch_select_i,
    input wire logic [3:0] nvm_linreg_setpoint_i,
    input wire logic switch_current_limit_enable_i,
    input wire logic test_board_mode_enable_i,
    input wire logic linreg_run_enable_o,
    input wire logic linreg_standby_enable_o,
    input wire logic [3:0] linreg_run_setpoint_o,
    input wire logic [3:0] linreg_standby_setpoint_o,
    input wire logic linreg_switch_select_o,
    input wire lrc_pkg::lrc_mode_t mode_o,
    input wire logic reg_on_o,
    input wire logic pass_through_o,
    input wire logic [3:0] active_setpoint_o,
    input wire logic discharge_o,
    input wire logic weak_pulldown_o,
    input wire logic current_limit_o
);
    logic run;
    logic sby;
    assign run = pwr_state_i == lrc_pkg::LRC_PWR_RUN;
    assign sby = pwr_state_i == lrc_pkg::LRC_PWR_STANDBY;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_run_off: assert property (run && !linreg_run_enable_o |=>
        !reg_on_o && discharge_o) else $error("run off broken");
    a_stby_off: assert property (sby && !linreg_standby_enable_o |=>
        !reg_on_o) else $error("standby off broken");
    a_mode_reg: assert property (run && linreg_run_enable_o &&
        !linreg_switch_select_o |=> mode_o == lrc_pkg::LRC_MODE_REGULATE
        && !pass_through_o) else $error("regulate mode broken");
    a_mode_sw: assert property (run && linreg_run_enable_o &&
        linreg_switch_select_o |=> mode_o == lrc_pkg::LRC_MODE_SWITCH
        && pass_through_o) else $error("switch mode broken");
    a_run_sp: assert property (run |=>
        active_setpoint_o == $past(linreg_run_setpoint_o))
        else $error("run set-point broken");
    a_stby_sp: assert property (sby |=>
        active_setpoint_o == $past(linreg_standby_setpoint_o))
        else $error("standby set-point broken");
    a_nvm_load: assert property (powerup_load_i |=>
        linreg_run_setpoint_o == $past(nvm_linreg_setpoint_i) &&
        linreg_standby_setpoint_o == $past(nvm_linreg_setpoint_i) &&
        !linreg_run_enable_o) else $error("load broken");
    a_sel_load: assert property (powerup_load_i |=>
        linreg_switch_select_o == $past(nvm_linreg_switch_select_i))
        else $error("switch select load broken");
    a_seq_set: assert property (seq_enable_i && in_sequence_i &&
        !powerup_load_i |=> linreg_run_enable_o && linreg_standby_enable_o)
        else $error("sequence enable broken");
    a_limit_gate: assert property (current_limit_o |->
        $past(switch_current_limit_enable_i) && pass_through_o)
        else $error("limit broken");
    a_weak_pd: assert property (test_board_mode_enable_i &&
        pwr_state_i == lrc_pkg::LRC_PWR_QOFF |=> weak_pulldown_o &&
        !discharge_o) else $error("weak pull-down broken");
    c_switch: cover property (mode_o == lrc_pkg::LRC_MODE_SWITCH);
    c_weak: cover property (weak_pulldown_o);
    c_limit: cover property (current_limit_o);
endmodule
bind lrc_linreg_ctrl lrc_linreg_ctrl_monitor u_lrc_linreg_ctrl_monitor (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pwr_state_i(pwr_state_i),
    .powerup_load_i(powerup_load_i),
    .in_sequence_i(in_sequence_i),
    .seq_enable_i(seq_enable_i),
    .nvm_linreg_switch_select_i(nvm_linreg_switch_select_i),
    .nvm_linreg_setpoint_i(nvm_linreg_setpoint_i),
    .switch_current_limit_enable_i(switch_current_limit_enable_i),
    .test_board_mode_enable_i(test_board_mode_enable_i),
    .linreg_run_enable_o(linreg_run_enable_o),
    .linreg_standby_enable_o(linreg_standby_enable_o),
    .linreg_run_setpoint_o(linreg_run_setpoint_o),
    .linreg_standby_setpoint_o(linreg_standby_setpoint_o),
    .linreg_switch_select_o(linreg_switch_select_o),
    .mode_o(mode_o),
    .reg_on_o(reg_on_o),
    .pass_through_o(pass_through_o),
    .active_setpoint_o(active_setpoint_o),
    .discharge_o(discharge_o),
    .weak_pulldown_o(weak_pulldown_o),
    .current_limit_o(current_limit_o)
);
`default_nettype wire

/* tb_lrc_linreg_ctrl.sv */
/* self-checking bench for lrc_linreg_ctrl.
 * assumes: lrc_pkg and the checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module tb_lrc_linreg_ctrl;
    logic clk_i = 0, rst_i = 1, powerup_load_i = 0, in_sequence_i = 0;
    logic seq_enable_i = 0, nvm_linreg_switch_select_i = 0;
    logic run_enable_we_i = 0, run_enable_wdata_i = 0;
    logic standby_enable_we_i = 0, standby_enable_wdata_i = 0;
    logic run_setpoint_we_i = 0, standby_setpoint_we_i = 0;
    logic switch_current_limit_enable_i = 0, test_board_mode_enable_i = 0;
    logic [3:0] nvm_linreg_setpoint_i = 4'h0, run_setpoint_wdata_i = 4'h0;
    logic [3:0] standby_setpoint_wdata_i = 4'h0;
    lrc_pkg::lrc_pwr_state_t pwr_state_i = lrc_pkg::LRC_PWR_OFF;
    logic linreg_run_enable_o, linreg_standby_enable_o;
    logic linreg_switch_select_o, reg_on_o, pass_through_o;
    logic discharge_o, weak_pulldown_o, current_limit_o;
    logic [3:0] linreg_run_setpoint_o, linreg_standby_setpoint_o;
    logic [3:0] active_setpoint_o;
    logic [12:0] target_mv_o;
    lrc_pkg::lrc_mode_t mode_o;
    int n_errors = 0, cmp_count = 0;
    always #5 clk_i = ~clk_i;
    lrc_linreg_ctrl u_lrc_linreg_ctrl (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pwr_state_i(pwr_state_i),
        .powerup_load_i(powerup_load_i),
        .in_sequence_i(in_sequence_i),
        .seq_enable_i(seq_enable_i),
        .nvm_linreg_switch_select_i(nvm_linreg_switch_select_i),
        .nvm_linreg_setpoint_i(nvm_linreg_setpoint_i),
        .run_enable_we_i(run_enable_we_i),
        .run_enable_wdata_i(run_enable_wdata_i),
        .standby_enable_we_i(standby_enable_we_i),
        .standby_enable_wdata_i(standby_enable_wdata_i),
        .run_setpoint_we_i(run_setpoint_we_i),
        .run_setpoint_wdata_i(run_setpoint_wdata_i),
        .standby_setpoint_we_i(standby_setpoint_we_i),
        .standby_setpoint_wdata_i(standby_setpoint_wdata_i),
        .switch_current_limit_enable_i(switch_current_limit_enable_i),
        .test_board_mode_enable_i(test_board_mode_enable_i),
        .linreg_run_enable_o(linreg_run_enable_o),
        .linreg_standby_enable_o(linreg_standby_enable_o),
        .linreg_run_setpoint_o(linreg_run_setpoint_o),
        .linreg_standby_setpoint_o(linreg_standby_setpoint_o),
        .linreg_switch_select_o(linreg_switch_select_o),
        .mode_o(mode_o),
        .reg_on_o(reg_on_o),
        .pass_through_o(pass_through_o),
        .active_setpoint_o(active_setpoint_o),
        .target_mv_o(target_mv_o),
        .discharge_o(discharge_o),
        .weak_pulldown_o(weak_pulldown_o),
        .current_limit_o(current_limit_o)
    );
    // ------------------------------
    // helpers
    // ------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: %h %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        if (n_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ------------------------------
    // scenarios
    // ------------------------------
    task automatic t_load;
        chk({linreg_run_enable_o, discharge_o}, 16'h0001);
        chk(target_mv_o, 16'h05DC);
        nvm_linreg_setpoint_i = 4'hF;
        powerup_load_i = 1;
        seq_enable_i = 1; // load wins over the same-cycle sequence strobe
        in_sequence_i = 1;
        step(1);
        powerup_load_i = 0;
        chk({linreg_run_setpoint_o, linreg_standby_setpoint_o}, 16'h00FF);
        step(1);
        seq_enable_i = 0;
        chk({linreg_run_enable_o, linreg_standby_enable_o}, 16'h0003);
    endtask
    task automatic t_run;
        pwr_state_i = lrc_pkg::LRC_PWR_RUN;
        step(3);
        chk({reg_on_o, pass_through_o}, 16'h0002);
        chk(mode_o, lrc_pkg::LRC_MODE_REGULATE);
        chk(target_mv_o, 16'h1388);
        run_enable_we_i = 1;
        step(1);
        run_enable_we_i = 0;
        step(2);
        chk({reg_on_o, discharge_o}, 16'h0001);
    endtask
    task automatic t_standby;
        standby_setpoint_we_i = 1;
        pwr_state_i = lrc_pkg::LRC_PWR_STANDBY;
        step(1);
        standby_setpoint_we_i = 0;
        step(3);
        chk({reg_on_o, active_setpoint_o}, 16'h0010);
        chk(target_mv_o, 16'h05DC);
        standby_enable_we_i = 1;
        step(1);
        standby_enable_we_i = 0;
        step(2);
        chk(reg_on_o, 16'h0000);
    endtask
    task automatic t_switch;
        nvm_linreg_switch_select_i = 1;
        in_sequence_i = 0;
        powerup_load_i = 1;
        step(1);
        powerup_load_i = 0;
        run_enable_we_i = 1;
        run_enable_wdata_i = 1;
        switch_current_limit_enable_i = 1;
        pwr_state_i = lrc_pkg::LRC_PWR_RUN;
        step(1);
        run_enable_we_i = 0;
        step(2);
        chk(linreg_standby_enable_o, 16'h0000);
        chk(mode_o, lrc_pkg::LRC_MODE_SWITCH);
        chk(linreg_switch_select_o, 16'h0001);
        chk({pass_through_o, current_limit_o}, 16'h0003);
        switch_current_limit_enable_i = 0;
        step(2);
        chk(current_limit_o, 16'h0000);
    endtask
    task automatic t_test;
        test_board_mode_enable_i = 1;
        pwr_state_i = lrc_pkg::LRC_PWR_QOFF;
        step(3);
        chk({weak_pulldown_o, discharge_o, reg_on_o}, 16'h0004);
    endtask
    initial
    begin
        step(20);
        rst_i = 0;
        step(1);
        t_load();
        t_run();
        t_standby();
        t_switch();
        t_test();
        final_report();
    end
    initial
    begin
        #5000;
        n_errors++;
        final_report();
    end
endmodule
`default_nettype wire
